// file: design/mac_ctrl_defs.svh
// Register offsets, field positions, reset values and timing figures of the MAC control block.
`ifndef MAC_CTRL_DEFS_SVH
`define MAC_CTRL_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OPMODE_OFS 8'h00
`define LINKSTAT_OFS 8'h04
`define SERTXRX_OFS 8'h08
`define STATUS_OFS 8'h0C

// ****************************************************************
// Field positions
// ****************************************************************
`define OPM_RX_START 1
`define OPM_FULL_DUPLEX 9
`define OPM_TX_START 13
`define OPM_CAPTURE 17
`define OPM_ENH_CAPTURE 31
`define LS_NEG_LO 12
`define LS_NEG_HI 14
`define LS_PARTNER_LO 21
`define LS_PARTNER_HI 25
`define SI_ADV_10HD 6
`define SI_ANEG_EN 7
`define SI_ADV_LO 16
`define SI_ADV_HI 18
`define ST_ANEG_DONE 0
`define ST_LINK_PASS 1
`define ST_TX_RUN 2
`define ST_RX_RUN 3

// ****************************************************************
// Field values and reset values
// ****************************************************************
`define NEG_IDLE 3'h0
`define NEG_RESTART 3'h1
`define NEG_BUSY 3'h2
`define NEG_COMPLETE 3'h5
`define OPMODE_RST 32'h00000000
`define SERTXRX_RST 32'h00000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_PS 5000
`define LINK_WAIT_MS 1000
`define SLOT_TIME_NS 51200
`define LINK_WAIT_CYC (64'd1000000000 * `LINK_WAIT_MS / `CLK_PERIOD_PS)
`define SLOT_CYC ((`SLOT_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BACKOFF_LIMIT 10

`endif

// file: design/mac_ctrl_pkg.sv
// Types shared by the MAC control block.
package mac_ctrl_pkg;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_SILENT = 6'h02,
		ST_NEGOTIATE = 6'h04,
		ST_LINK_TEST = 6'h08,
		ST_NO_COMMON = 6'h10,
		ST_LINK_UP = 6'h20
	} aneg_state_e;

	typedef enum logic [2:0] {
		MODE_NONE = 3'h0,
		MODE_10HD = 3'h1,
		MODE_10FD = 3'h2,
		MODE_TXHD = 3'h3,
		MODE_TXFD = 3'h4,
		MODE_T4 = 3'h5
	} link_mode_e;

endpackage

// file: design/backoff_timer.sv
// Collision backoff timer with 2-0 and stopped backoff variants.
`timescale 1ns/100ps
`include "mac_ctrl_defs.svh"

module backoff_timer #(
	parameter int SLOT_CYCLES = `SLOT_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Backoff request
	input wire logic i_start,
	input wire logic [3:0] i_attempt,
	input wire logic i_two_zero,
	input wire logic i_stop_en,
	input wire logic i_chan_busy,
	// Backoff state
	output logic o_busy,
	output logic o_done
);

	localparam int CW = $clog2(SLOT_CYCLES + 1);

	logic [15:0] lfsr_q;
	logic [9:0] slots_q;
	logic [9:0] slots_d;
	logic [9:0] mask;
	logic [3:0] k;
	logic [CW-1:0] cyc_q;
	logic busy_q;
	logic done_q;
	logic stop_q;

	// Free-running so the sampled value depends on when collisions occur.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lfsr_q <= 16'hACE1;
		end else begin
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		end
	end

	always_comb begin
		k = (i_attempt > 4'(`BACKOFF_LIMIT)) ? 4'(`BACKOFF_LIMIT) : i_attempt;
		mask = ~(10'h3FF << k);
		if (i_two_zero && i_attempt == 4'h1) begin
			slots_d = 10'h002;
		end else if (i_two_zero && i_attempt == 4'h2) begin
			slots_d = 10'h000;
		end else begin
			slots_d = lfsr_q[9:0] & mask;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			stop_q <= 1'b0;
			slots_q <= 10'h000;
			cyc_q <= '0;
		end else begin
			done_q <= 1'b0;
			if (i_start) begin
				busy_q <= 1'b1;
				slots_q <= slots_d;
				cyc_q <= '0;
				stop_q <= i_stop_en;
			end else if (busy_q) begin
				if (stop_q && i_chan_busy) begin
					cyc_q <= cyc_q;
				end else if (slots_q == 10'h000) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end else if (cyc_q == CW'(SLOT_CYCLES - 1)) begin
					cyc_q <= '0;
					slots_q <= slots_q - 10'h001;
				end else begin
					cyc_q <= cyc_q + CW'(1);
				end
			end
		end
	end

	assign o_busy = busy_q;
	assign o_done = done_q;

	AST_TWO_SLOTS: assert property (@(posedge clk) disable iff (!nrst)
		i_start && i_two_zero && i_attempt == 4'h1 |=> slots_q == 10'h002)
		else $error("2-0 backoff did not load two slots");
	AST_ZERO_SLOTS: assert property (@(posedge clk) disable iff (!nrst)
		i_start && i_two_zero && i_attempt == 4'h2 |=> ##1 done_q)
		else $error("2-0 backoff did not finish at once on second collision");
	AST_NO_FREEZE: assert property (@(posedge clk) disable iff (!nrst)
		busy_q && !stop_q && !i_start && slots_q != 10'h000 && i_chan_busy
		&& cyc_q != CW'(SLOT_CYCLES - 1) |=> cyc_q == $past(cyc_q) + CW'(1))
		else $error("Backoff timer paused outside first retransmission");

endmodule

// file: design/duplex_autoneg_backoff_ctrl.sv
// Duplex, link negotiation and capture-effect backoff control of a 10/100 MAC.
`timescale 1ns/100ps
`include "mac_ctrl_defs.svh"

module duplex_autoneg_backoff_ctrl #(
	parameter longint LINK_WAIT_CYCLES = `LINK_WAIT_CYC,
	parameter int SLOT_CYCLES = `SLOT_CYC
) (
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_NRST,
	// AXI4-Lite write
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [7:0] I_AWADDR,
	input wire logic I_WVALID,
	output logic O_WREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	output logic O_BVALID,
	input wire logic I_BREADY,
	output logic [1:0] O_BRESP,
	// AXI4-Lite read
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	input wire logic [7:0] I_ARADDR,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	// Link side pins
	input wire logic I_CARRIER,
	input wire logic I_COLLISION,
	input wire logic I_LINK_PASS,
	input wire logic I_PARTNER_VALID,
	input wire logic [4:0] I_PARTNER_CODE,
	output logic O_LINK_PULSE_EN,
	output logic O_PATH_EN,
	output logic [2:0] O_LINK_MODE,
	output logic O_FULL_DUPLEX,
	output logic O_ANEG_DONE,
	// Transmit engine
	input wire logic I_TX_OK,
	input wire logic I_TX_COLL,
	input wire logic [3:0] I_TX_ATTEMPT,
	input wire logic I_FRAME_SENSED,
	output logic O_CARRIER,
	output logic O_COLLISION,
	output logic O_TX_RUN,
	output logic O_RX_RUN,
	output logic O_BACKOFF_BUSY,
	output logic O_BACKOFF_DONE
);

	localparam int NSYNC = 9;

	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	logic crs_s;
	logic col_s;
	logic lpass_s;
	logic pvalid_s;
	logic [4:0] pcode_s;
	logic [31:0] opmode_q;
	logic [31:0] sertxrx_q;
	logic [4:0] partner_q;
	logic done_sticky_q;
	logic lpass_sticky_q;
	logic up_q;
	logic bvalid_q;
	logic rvalid_q;
	logic [1:0] bresp_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic wr_go;
	logic rd_go;
	logic restart_wr;
	logic done_clr;
	mac_ctrl_pkg::aneg_state_e state_q;
	mac_ctrl_pkg::link_mode_e mode_q;
	mac_ctrl_pkg::link_mode_e mode_d;
	logic [27:0] tmr_q;
	logic tmr_end;
	logic aneg_en;
	logic aneg_en_q;
	logic done_q;
	logic [2:0] neg_field;
	logic fd_eff;
	logic two_zero_q;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	assign pin_raw = {I_PARTNER_CODE, I_PARTNER_VALID, I_LINK_PASS, I_COLLISION, I_CARRIER};

	genvar g;
	generate
		for (g = 0; g < NSYNC; g++) begin : g_sync
			always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
				if (!I_NRST) begin
					sync1_q[g] <= 1'b0;
					sync2_q[g] <= 1'b0;
				end else begin
					sync1_q[g] <= pin_raw[g];
					sync2_q[g] <= sync1_q[g];
				end
			end
		end
	endgenerate

	assign crs_s = sync2_q[0];
	assign col_s = sync2_q[1];
	assign lpass_s = sync2_q[2];
	assign pvalid_s = sync2_q[3];
	assign pcode_s = sync2_q[8:4];

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	// Address and data are taken together, which keeps a single write path.
	assign wr_go = I_AWVALID && I_WVALID && !bvalid_q;
	assign rd_go = I_ARVALID && !rvalid_q;
	assign O_AWREADY = wr_go;
	assign O_WREADY = wr_go;
	assign O_ARREADY = rd_go;
	assign O_BVALID = bvalid_q;
	assign O_BRESP = bresp_q;
	assign O_RVALID = rvalid_q;
	assign O_RDATA = rdata_q;
	assign O_RRESP = rresp_q;
	assign restart_wr = wr_go && I_AWADDR == `LINKSTAT_OFS && I_WSTRB[1]
		&& I_WDATA[`LS_NEG_HI:`LS_NEG_LO] == `NEG_RESTART;
	assign done_clr = wr_go && I_AWADDR == `STATUS_OFS && I_WSTRB[0] && I_WDATA[`ST_ANEG_DONE];

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			opmode_q <= `OPMODE_RST;
			sertxrx_q <= `SERTXRX_RST;
		end else if (wr_go) begin
			for (int b = 0; b < 4; b++) begin
				if (I_WSTRB[b] && I_AWADDR == `OPMODE_OFS) begin
					opmode_q[b*8 +: 8] <= I_WDATA[b*8 +: 8];
				end
				if (I_WSTRB[b] && I_AWADDR == `SERTXRX_OFS) begin
					sertxrx_q[b*8 +: 8] <= I_WDATA[b*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q <= (I_AWADDR == `OPMODE_OFS || I_AWADDR == `LINKSTAT_OFS
				|| I_AWADDR == `SERTXRX_OFS || I_AWADDR == `STATUS_OFS) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (I_BREADY) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rvalid_q <= 1'b0;
			rresp_q <= `RESP_OKAY;
			rdata_q <= 32'h00000000;
		end else if (rd_go) begin
			rvalid_q <= 1'b1;
			rresp_q <= `RESP_OKAY;
			unique case (I_ARADDR)
				`OPMODE_OFS: rdata_q <= opmode_q;
				`SERTXRX_OFS: rdata_q <= sertxrx_q;
				`LINKSTAT_OFS: begin
					rdata_q <= 32'h00000000;
					rdata_q[`LS_PARTNER_HI:`LS_PARTNER_LO] <= partner_q;
					rdata_q[`LS_NEG_HI:`LS_NEG_LO] <= neg_field;
					rdata_q[2:0] <= mode_q;
				end
				`STATUS_OFS: begin
					rdata_q <= 32'h00000000;
					rdata_q[`ST_ANEG_DONE] <= done_sticky_q;
					rdata_q[`ST_LINK_PASS] <= lpass_sticky_q;
					rdata_q[`ST_TX_RUN] <= O_TX_RUN;
					rdata_q[`ST_RX_RUN] <= O_RX_RUN;
				end
				default: begin
					rdata_q <= 32'h00000000;
					rresp_q <= `RESP_SLVERR;
				end
			endcase
		end else if (I_RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	// A new event in the clearing cycle keeps the flag set.
	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			done_sticky_q <= 1'b0;
			lpass_sticky_q <= 1'b0;
			up_q <= 1'b0;
		end else begin
			up_q <= state_q == mac_ctrl_pkg::ST_LINK_UP;
			done_sticky_q <= done_q || (done_sticky_q && !done_clr);
			lpass_sticky_q <= (state_q == mac_ctrl_pkg::ST_LINK_UP && !up_q)
				|| (lpass_sticky_q && !(wr_go && I_AWADDR == `STATUS_OFS
				&& I_WSTRB[0] && I_WDATA[`ST_LINK_PASS]));
		end
	end

	// ****************************************************************
	// Link negotiation
	// ****************************************************************
	assign aneg_en = sertxrx_q[`SI_ANEG_EN];
	assign tmr_end = tmr_q == 28'(LINK_WAIT_CYCLES - 1);

	always_comb begin
		logic [2:0] a;
		logic hd;
		logic fd;
		logic [4:0] p;
		a = sertxrx_q[`SI_ADV_HI:`SI_ADV_LO];
		hd = sertxrx_q[`SI_ADV_10HD];
		fd = opmode_q[`OPM_FULL_DUPLEX];
		p = partner_q;
		if (p[3] && a[1]) mode_d = mac_ctrl_pkg::MODE_TXFD;
		else if (p[2] && a == 3'h1) mode_d = mac_ctrl_pkg::MODE_TXHD;
		else if (p[4:2] == 3'h1 && a[0]) mode_d = mac_ctrl_pkg::MODE_TXHD;
		else if (p[1] && a == 3'h0 && fd) mode_d = mac_ctrl_pkg::MODE_10FD;
		else if (p[4:1] == 4'h1 && fd) mode_d = mac_ctrl_pkg::MODE_10FD;
		else if (p[0] && a == 3'h0 && hd && !fd) mode_d = mac_ctrl_pkg::MODE_10HD;
		else if (p == 5'h01 && hd) mode_d = mac_ctrl_pkg::MODE_10HD;
		else if (p[4] && a[2:1] == 2'h2) mode_d = mac_ctrl_pkg::MODE_T4;
		else if (p[4:3] == 2'h2 && a[2]) mode_d = mac_ctrl_pkg::MODE_T4;
		else mode_d = mac_ctrl_pkg::MODE_NONE;
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			state_q <= mac_ctrl_pkg::ST_IDLE;
			tmr_q <= 28'h0000000;
			aneg_en_q <= 1'b0;
			done_q <= 1'b0;
			partner_q <= 5'h00;
			mode_q <= mac_ctrl_pkg::MODE_NONE;
		end else begin
			aneg_en_q <= aneg_en;
			done_q <= 1'b0;
			tmr_q <= tmr_end ? tmr_q : tmr_q + 28'h0000001;
			if (!aneg_en) begin
				state_q <= mac_ctrl_pkg::ST_IDLE;
			end else if (restart_wr || !aneg_en_q) begin
				state_q <= mac_ctrl_pkg::ST_SILENT;
				tmr_q <= 28'h0000000;
			end else begin
				unique case (state_q)
					mac_ctrl_pkg::ST_IDLE: begin
						state_q <= mac_ctrl_pkg::ST_SILENT;
						tmr_q <= 28'h0000000;
					end
					mac_ctrl_pkg::ST_SILENT: if (tmr_end) begin
						state_q <= mac_ctrl_pkg::ST_NEGOTIATE;
					end
					mac_ctrl_pkg::ST_NEGOTIATE: if (pvalid_s) begin
						partner_q <= pcode_s;
						state_q <= mac_ctrl_pkg::ST_LINK_TEST;
						tmr_q <= 28'h0000000;
					end
					mac_ctrl_pkg::ST_LINK_TEST: begin
						mode_q <= mode_d;
						if (tmr_q == 28'h0000000) begin
							done_q <= 1'b1;
						end
						if (mode_d == mac_ctrl_pkg::MODE_NONE) begin
							state_q <= mac_ctrl_pkg::ST_NO_COMMON;
						end else if (lpass_s) begin
							state_q <= mac_ctrl_pkg::ST_LINK_UP;
						end else if (tmr_end) begin
							state_q <= mac_ctrl_pkg::ST_SILENT;
							tmr_q <= 28'h0000000;
						end
					end
					mac_ctrl_pkg::ST_NO_COMMON: if (tmr_end) begin
						state_q <= mac_ctrl_pkg::ST_SILENT;
						tmr_q <= 28'h0000000;
					end
					mac_ctrl_pkg::ST_LINK_UP: if (!lpass_s) begin
						state_q <= mac_ctrl_pkg::ST_SILENT;
						tmr_q <= 28'h0000000;
					end
				endcase
			end
		end
	end

	always_comb begin
		unique case (state_q)
			mac_ctrl_pkg::ST_IDLE: neg_field = `NEG_IDLE;
			mac_ctrl_pkg::ST_SILENT: neg_field = `NEG_RESTART;
			mac_ctrl_pkg::ST_NEGOTIATE: neg_field = `NEG_BUSY;
			default: neg_field = `NEG_COMPLETE;
		endcase
	end

	assign O_ANEG_DONE = done_q;
	assign O_LINK_MODE = mode_q;
	assign O_LINK_PULSE_EN = state_q != mac_ctrl_pkg::ST_SILENT;
	assign O_PATH_EN = !aneg_en || state_q == mac_ctrl_pkg::ST_LINK_UP;

	// ****************************************************************
	// Duplex and process control
	// ****************************************************************
	assign fd_eff = opmode_q[`OPM_FULL_DUPLEX] && (!aneg_en || mode_q == mac_ctrl_pkg::MODE_10FD
		|| mode_q == mac_ctrl_pkg::MODE_TXFD);
	assign O_FULL_DUPLEX = fd_eff;
	assign O_CARRIER = crs_s && !fd_eff;
	assign O_COLLISION = col_s && !fd_eff;
	assign O_TX_RUN = opmode_q[`OPM_TX_START] && O_PATH_EN;
	assign O_RX_RUN = opmode_q[`OPM_RX_START] && O_PATH_EN;

	// ****************************************************************
	// Capture-effect backoff
	// ****************************************************************
	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			two_zero_q <= 1'b0;
		end else begin
			two_zero_q <= (opmode_q[`OPM_CAPTURE] && I_TX_OK)
				|| (two_zero_q && !I_FRAME_SENSED && opmode_q[`OPM_CAPTURE]);
		end
	end

	backoff_timer #(
		.SLOT_CYCLES(SLOT_CYCLES)
	) u_backoff (
		.clk(I_SYS_CLK),
		.nrst(I_NRST),
		.i_start(I_TX_COLL && !fd_eff),
		.i_attempt(I_TX_ATTEMPT),
		.i_two_zero(two_zero_q),
		.i_stop_en(opmode_q[`OPM_ENH_CAPTURE] && two_zero_q && I_TX_ATTEMPT == 4'h1),
		.i_chan_busy(crs_s),
		.o_busy(O_BACKOFF_BUSY),
		.o_done(O_BACKOFF_DONE)
	);

	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_NRST);

	AST_FD_IGNORE: assert property (fd_eff |-> !O_CARRIER && !O_COLLISION)
		else $error("Carrier or collision passed in full duplex");
	AST_RUN_INDEP: assert property (O_PATH_EN && opmode_q[`OPM_TX_START] |-> O_TX_RUN)
		else $error("Transmit not running with path enabled");
	AST_FD_NEG: assert property (aneg_en && mode_q == mac_ctrl_pkg::MODE_10HD |-> !O_FULL_DUPLEX)
		else $error("Full duplex entered against negotiated mode");
	AST_SILENT: assert property (state_q == mac_ctrl_pkg::ST_SILENT |-> !O_LINK_PULSE_EN)
		else $error("Link pulses sent during silence");
	AST_SILENT_LEN: assert property (state_q == mac_ctrl_pkg::ST_SILENT
		##1 state_q == mac_ctrl_pkg::ST_NEGOTIATE |-> $past(tmr_end))
		else $error("Silence ended before its full length");
	AST_DONE_FIELD: assert property ($rose(done_q) |-> neg_field == 3'h5 ##1 done_sticky_q)
		else $error("Negotiation completion not shown");
	AST_RESTART: assert property (restart_wr && aneg_en |=> state_q == mac_ctrl_pkg::ST_SILENT)
		else $error("Restart write did not restart negotiation");
	AST_NOCOMMON: assert property (state_q == mac_ctrl_pkg::ST_NO_COMMON && tmr_end && aneg_en
		&& !restart_wr |=> state_q == mac_ctrl_pkg::ST_SILENT)
		else $error("No common mode did not restart");
	AST_PATH: assert property (aneg_en && O_PATH_EN |-> mode_q != mac_ctrl_pkg::MODE_NONE)
		else $error("Paths enabled without a negotiated mode");
	AST_REVERT: assert property (I_FRAME_SENSED && !I_TX_OK |=> !two_zero_q)
		else $error("2-0 backoff kept after a sensed frame");
	AST_CAPTURE_OFF: assert property (!opmode_q[`OPM_CAPTURE] |=> !two_zero_q)
		else $error("2-0 backoff active while disabled");

endmodule

// file: sim/link_partner_model.sv
// Behavioural remote link partner across the twisted pair.
`timescale 1ns/100ps
module link_partner_model (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Bench control
	input wire logic [4:0] i_code,
	input wire logic i_pass_en,
	input wire logic [7:0] i_dly,
	// Medium
	input wire logic i_pulse_en,
	output logic o_valid,
	output logic [4:0] o_code,
	output logic o_pass
);
	logic pulse_q;
	int cnt_q;
	// The code lines toggle outside an exchange, so a stale word is never taken as fresh.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pulse_q <= 1'b1;
			cnt_q <= 0;
			o_valid <= 1'b0;
			o_code <= 5'h00;
			o_pass <= 1'b0;
		end else begin
			pulse_q <= i_pulse_en;
			o_valid <= cnt_q > 1 && cnt_q < 7;
			o_code <= (cnt_q > 1 && cnt_q < 7) ? i_code : ~o_code;
			if (!i_pulse_en) begin
				cnt_q <= 0;
				o_pass <= 1'b0;
			end else if (!pulse_q) begin
				cnt_q <= i_dly + 7;
			end else if (cnt_q > 0) begin
				cnt_q <= cnt_q - 1;
				if (cnt_q == 1) o_pass <= i_pass_en;
			end
		end
	end
endmodule

// file: sim/tb_duplex_autoneg_backoff_ctrl.sv
// Self-checking bench of the duplex, negotiation and backoff control block.
`timescale 1ns/100ps
`include "mac_ctrl_defs.svh"
module tb_duplex_autoneg_backoff_ctrl;
	typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] rs;
		logic [1:0] run;} row_s;
	typedef struct packed {logic [4:0] code; logic pass; logic [2:0] mode; logic fd;} neg_s;
	logic I_SYS_CLK = 1'b0;
	logic I_NRST = 1'b0;
	logic I_AWVALID = 1'b0, I_WVALID = 1'b0, I_ARVALID = 1'b0, I_BREADY = 1'b1, I_RREADY = 1'b1;
	logic I_CARRIER = 1'b0, I_COLLISION = 1'b0, I_TX_OK = 1'b0, I_TX_COLL = 1'b0;
	logic I_FRAME_SENSED = 1'b0;
	logic [7:0] I_AWADDR = 8'h00, I_ARADDR = 8'h00;
	logic [31:0] I_WDATA = 32'h00000000;
	logic [3:0] I_WSTRB = 4'h0, I_TX_ATTEMPT = 4'h0;
	logic I_LINK_PASS, I_PARTNER_VALID;
	logic [4:0] I_PARTNER_CODE;
	logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_LINK_PULSE_EN, O_PATH_EN;
	logic O_FULL_DUPLEX, O_ANEG_DONE, O_CARRIER, O_COLLISION, O_TX_RUN, O_RX_RUN;
	logic O_BACKOFF_BUSY, O_BACKOFF_DONE;
	logic [1:0] O_BRESP, O_RRESP;
	logic [31:0] O_RDATA;
	logic [2:0] O_LINK_MODE;
	logic [4:0] p_code = 5'h00;
	logic p_pass = 1'b0;
	logic [7:0] p_dly = 8'h03;
	logic [31:0] d;
	logic [1:0] r;
	int c;
	int num_errors = 0;
	int num_checks = 0;
	row_s rows [5] = '{
		'{8'h00, 32'h00002002, 32'h00002002, 2'h0, 2'h3},
		'{8'h00, 32'h00000002, 32'h00000002, 2'h0, 2'h1},
		'{8'h00, 32'h00022000, 32'h00022000, 2'h0, 2'h2},
		'{8'h08, 32'h00070040, 32'h00070040, 2'h0, 2'h2},
		'{8'h10, 32'hFFFFFFFF, 32'h00000000, 2'h2, 2'h2}};
	neg_s negs [5] = '{'{5'h08, 1'b1, 3'h4, 1'b1}, '{5'h01, 1'b1, 3'h1, 1'b0},
		'{5'h02, 1'b1, 3'h2, 1'b1}, '{5'h00, 1'b0, 3'h0, 1'b0}, '{5'h08, 1'b0, 3'h4, 1'b0}};

	duplex_autoneg_backoff_ctrl #(.LINK_WAIT_CYCLES(50), .SLOT_CYCLES(8)) i_dut (.*);
	link_partner_model i_lp (.clk(I_SYS_CLK), .nrst(I_NRST), .i_code(p_code),
		.i_pass_en(p_pass), .i_dly(p_dly), .i_pulse_en(O_LINK_PULSE_EN),
		.o_valid(I_PARTNER_VALID), .o_code(I_PARTNER_CODE), .o_pass(I_LINK_PASS));

	initial begin
		forever #2.5 I_SYS_CLK = ~I_SYS_CLK;
	end

	// ****************************************************************
	// Bus, stimulus and compare tasks
	// ****************************************************************
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
		num_checks++;
		if (v !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", s, e, v);
		end
	endtask

	task automatic rng(input string s, input int v, input int lo, input int hi);
		num_checks++;
		if (v < lo || v > hi) begin
			num_errors++;
			$display("ERROR %s expected %0d..%0d seen %0d", s, lo, hi, v);
		end
	endtask

	task automatic wrap_up;
		$display("Checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Ready is sampled before the edge's own updates land, so the handshake edge is exact.
	task automatic wr(input logic [7:0] a, input logic [31:0] w, output logic [1:0] rs);
		int t;
		t = 0;
		I_AWVALID <= 1'b1;
		I_AWADDR <= a;
		I_WVALID <= 1'b1;
		I_WDATA <= w;
		I_WSTRB <= 4'hF;
		do begin
			@(posedge I_SYS_CLK);
			t++;
			if (O_AWREADY === 1'b1) I_AWVALID <= 1'b0;
			if (O_WREADY === 1'b1) I_WVALID <= 1'b0;
		end while (O_BVALID !== 1'b1 && t < 50);
		if (O_BVALID !== 1'b1) num_errors++;
		rs = O_BRESP;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int t;
		t = 0;
		I_ARVALID <= 1'b1;
		I_ARADDR <= a;
		do begin
			@(posedge I_SYS_CLK);
			t++;
			if (O_ARREADY === 1'b1) I_ARVALID <= 1'b0;
		end while (O_RVALID !== 1'b1 && t < 50);
		if (O_RVALID !== 1'b1) num_errors++;
		v = O_RDATA;
		rs = O_RRESP;
	endtask

	task automatic pls(input logic sense);
		I_TX_OK <= !sense;
		I_FRAME_SENSED <= sense;
		@(posedge I_SYS_CLK);
		I_TX_OK <= 1'b0;
		I_FRAME_SENSED <= 1'b0;
		@(posedge I_SYS_CLK);
	endtask

	task automatic bo(input logic [3:0] n, input int busy, output int cy);
		I_TX_COLL <= 1'b1;
		I_TX_ATTEMPT <= n;
		I_CARRIER <= busy > 0;
		cy = 0;
		@(posedge I_SYS_CLK);
		I_TX_COLL <= 1'b0;
		while (O_BACKOFF_DONE !== 1'b1 && cy < 2000) begin
			@(posedge I_SYS_CLK);
			cy++;
			if (cy == 1) chk("bo_busy", 1, O_BACKOFF_BUSY);
			if (cy == busy) I_CARRIER <= 1'b0;
		end
		chk("bo_idle", 0, O_BACKOFF_BUSY);
		@(posedge I_SYS_CLK);
	endtask

	function automatic logic sig(input int w);
		case (w)
			0: return O_LINK_PULSE_EN;
			1: return O_ANEG_DONE;
			default: return O_PATH_EN;
		endcase
	endfunction

	task automatic wt(input int w, input logic v, output int cy);
		cy = 0;
		while (sig(w) !== v && cy < 500) begin
			@(posedge I_SYS_CLK);
			cy++;
		end
		if (sig(w) !== v) num_errors++;
	endtask

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		repeat (8) @(posedge I_SYS_CLK);
		I_NRST <= 1'b1;
		@(posedge I_SYS_CLK);
		chk("pulse_en", 1, O_LINK_PULSE_EN);
		chk("path_en", 1, O_PATH_EN);
		rd(`OPMODE_OFS, d, r);
		chk("opmode", `OPMODE_RST, d);
		rd(`SERTXRX_OFS, d, r);
		chk("sertxrx", `SERTXRX_RST, d);
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].w, r);
			chk("bresp", rows[k].rs, r);
			rd(rows[k].a, d, r);
			chk("rdata", rows[k].e, d);
			chk("rresp", rows[k].rs, r);
			chk("run", rows[k].run, {O_TX_RUN, O_RX_RUN});
		end
		pls(1'b0);
		bo(4'h1, 0, c);
		rng("two_slot", c, 16, 21);
		bo(4'h2, 0, c);
		rng("zero_slot", c, 0, 4);
		pls(1'b1);
		bo(4'h1, 0, c);
		rng("standard", c, 0, 11);
		bo(4'h3, 0, c);
		rng("random", c, 0, 59);
		wr(`OPMODE_OFS, 32'h80022000, r);
		pls(1'b0);
		bo(4'h1, 20, c);
		rng("frozen", c, 33, 42);
		I_CARRIER <= 1'b1;
		repeat (3) @(posedge I_SYS_CLK);
		bo(4'h2, 20, c);
		rng("not_frozen", c, 0, 4);
		wr(`OPMODE_OFS, 32'h00022000, r);
		pls(1'b0);
		bo(4'h1, 20, c);
		rng("enh_off", c, 16, 21);
		wr(`OPMODE_OFS, 32'h80002000, r);
		pls(1'b0);
		bo(4'h1, 0, c);
		rng("capture_off", c, 0, 11);
		wr(`OPMODE_OFS, 32'h00002200, r);
		I_CARRIER <= 1'b1;
		I_COLLISION <= 1'b1;
		repeat (4) @(posedge I_SYS_CLK);
		chk("carrier", 0, O_CARRIER);
		chk("collision", 0, O_COLLISION);
		wr(`OPMODE_OFS, 32'h00000000, r);
		repeat (3) @(posedge I_SYS_CLK);
		chk("carrier", 1, O_CARRIER);
		chk("collision", 1, O_COLLISION);
		I_CARRIER <= 1'b0;
		I_COLLISION <= 1'b0;
		rd(`STATUS_OFS, d, r);
		chk("proc_state", 0, d[3:2]);
		wr(`OPMODE_OFS, 32'h00000200, r);
		foreach (negs[k]) begin
			p_code <= negs[k].code;
			p_pass <= negs[k].pass;
			p_dly <= 8'(3 + 40 * k);
			if (k == 0) wr(`SERTXRX_OFS, 32'h000200C0, r);
			else wr(`LINKSTAT_OFS, 32'h00001000, r);
			wt(0, 1'b0, c);
			wt(0, 1'b1, c);
			rng("silence", c, 48, 54);
			wt(1, 1'b1, c);
			chk("mode", negs[k].mode, O_LINK_MODE);
			chk("path_early", 0, O_PATH_EN);
			rd(`LINKSTAT_OFS, d, r);
			chk("neg_state", 3'h5, d[14:12]);
			if (negs[k].pass) begin
				wt(2, 1'b1, c);
				rng("path_wait", c, 0, 20);
				chk("full_duplex", negs[k].fd, O_FULL_DUPLEX);
				rd(`STATUS_OFS, d, r);
				chk("link_flag", 1, d[1]);
				chk("done_flag", 1, d[0]);
				wr(`STATUS_OFS, 32'h00000003, r);
				wr(`OPMODE_OFS, 32'h00002202, r);
				chk("tx_run", 1, O_TX_RUN);
			end else begin
				wt(0, 1'b0, c);
				rng("renegotiate", c, 45, 56);
				chk("path_fail", 0, O_PATH_EN);
				wt(0, 1'b1, c);
			end
		end
		wrap_up();
	end

	initial begin
		#100000;
		num_errors++;
		wrap_up();
	end
endmodule
